// file: include/dpts_pkg.sv
// Package of constants and types for the dual potentiometer serial slave
package dpts_pkg;

    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int STRAP_W    = 3;    // Strap bits, eight slaves per bus
    localparam int POTS       = 2;
    localparam int SAVED_NUM  = 4;    // Saved positions per potentiometer
    localparam int TAPS       = 256;  // Tap switches per potentiometer
    localparam int REG_ADDR_W = 4;

    // Device type nibble in the identification byte; value is arbitrary
    localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h9;

    // ---------------------------------------------------------------
    // Serial bit counter marks
    // ---------------------------------------------------------------
    localparam logic [3:0] BIT_ACK  = 4'h8;  // Eight data bits seen
    localparam logic [3:0] BIT_DONE = 4'h9;  // Ninth clock high seen

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0]      WIPER_RESET = 8'h00;
    localparam logic [7:0]      SAVED_RESET = 8'h80;
    localparam logic [TAPS-1:0] TAP_RESET   = 256'h1;

    // ---------------------------------------------------------------
    // Register port map
    // ---------------------------------------------------------------
    localparam logic [REG_ADDR_W-1:0] REG_WIPER0  = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_WIPER1  = 4'h1;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS  = 4'h2;
    localparam logic [REG_ADDR_W-1:0] REG_CONTROL = 4'h3;
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_REFUSED_BIT = 1;
    localparam int STAT_WP_BIT      = 2;
    localparam int CTRL_RECALL_BIT  = 0;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ID     = 3'b001,
        ST_INSTR  = 3'b010,
        ST_RX     = 3'b011,
        ST_TX     = 3'b100,
        ST_IGNORE = 3'b101
    } dpts_state_type;

    // Instruction byte layout
    typedef struct packed {
        logic       rd;         // 1: slave sends the selected register
        logic [1:0] spare_hi;
        logic       saved_sel;  // 1: saved position, 0: wiper position
        logic [1:0] rptr;       // Saved position index
        logic       spare_lo;
        logic       pot;        // Potentiometer select
    } dpts_instr_type;

    // Register port request
    typedef struct packed {
        logic [REG_ADDR_W-1:0] addr;
        logic [7:0]            wdata;
        logic                  wr;
        logic                  rd;
    } dpts_bus_req_type;

endpackage

// file: core/dpts_tap_decoder.sv
// One-hot tap switch decoder for one potentiometer wiper
module dpts_tap_decoder
    import dpts_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            reset_n,
    input  wire logic [7:0]      wiper,
    output logic      [TAPS-1:0] tap_en
);

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    // Registered so exactly one switch is ever on, never a glitch of two
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tap_en <= TAP_RESET;
        end else begin
            tap_en <= TAP_RESET << wiper;
        end
    end

endmodule // dpts_tap_decoder

// file: core/dpts_core.sv
// Serial slave and register core of the dual digital potentiometer
// How it works
// - Sample data on each rising serial clock
// - Change sent data only after falling clock
// - Data line open drain: pull low or release
// - Continue only when address matches strap inputs
// - Strap bits give eight slaves per bus
// - Each pot: wiper plus four saved registers
// - Wiper value selects one of 256 taps
// - Power-up copies default saved into wiper
// - Eight-bit wiper decoded one-hot to switches
// - Write-protect low refuses saved register writes
//
// Implementation choices: the register addresses and strobed register access.
module dpts_core
    import dpts_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEFAULT
)
(
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   scl,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe_n,
    input  wire logic [STRAP_W-1:0]     address_strap_inputs,
    input  wire logic                   wp,
    input  wire dpts_bus_req_type       bus_req,
    output logic      [7:0]             rdata,
    output logic      [TAPS-1:0]        wiper_out_0,
    output logic      [TAPS-1:0]        wiper_out_1
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    localparam int PIN_W = STRAP_W + 3;

    logic [PIN_W-1:0]   pin_meta_r;
    logic [PIN_W-1:0]   pin_sync_r;
    logic               scl_s;
    logic               sda_s;
    logic               wp_s;
    logic [STRAP_W-1:0] strap_s;
    logic               scl_d_r;
    logic               sda_d_r;

    // All pins are asynchronous to mclk, so each passes two flops
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_r <= '1;  // Idle bus level, so no false edge
            pin_sync_r <= '1;
        end else begin
            pin_meta_r <= {address_strap_inputs, wp, sda_in, scl};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign scl_s   = pin_sync_r[0];
    assign sda_s   = pin_sync_r[1];
    assign wp_s    = pin_sync_r[2];
    assign strap_s = pin_sync_r[PIN_W-1:3];

    // Delayed copies for edge and start/stop detection
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // ---------------------------------------------------------------
    // Bus events
    // ---------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // Data moving while the clock is high marks start or stop
    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ---------------------------------------------------------------
    // Serial state
    // ---------------------------------------------------------------
    dpts_state_type state_r;
    logic [3:0]     bit_cnt_r;
    logic [7:0]     shift_r;
    dpts_instr_type instr_r;
    logic           master_ack_r;
    logic           sda_oe_n_r;
    logic           sda_out_r;

    logic [7:0]     wiper_r [0:POTS-1];
    logic [7:0]     saved_r [0:POTS-1][0:SAVED_NUM-1];

    logic           byte_end;
    logic           id_match;
    logic           refused;
    logic           byte_ok;
    logic           write_fire;
    logic           refuse_evt;
    logic [7:0]     tx_byte;

    // Identification byte: type nibble high, strap bits low
    assign id_match = (shift_r[7:4] == DEV_TYPE) &&
                      (shift_r[STRAP_W-1:0] == strap_s);

    // Saved positions are protected while the protect pin is low
    assign refused    = instr_r.saved_sel & ~wp_s;
    assign byte_end   = scl_fall && (bit_cnt_r == BIT_ACK);
    assign write_fire = byte_end && (state_r == ST_RX) && !refused;
    assign refuse_evt = byte_end && (state_r == ST_RX) && refused;

    always_comb begin
        byte_ok = 1'b0;
        unique case (state_r)
            ST_ID:    byte_ok = id_match;
            ST_INSTR: byte_ok = 1'b1;
            ST_RX:    byte_ok = !refused;
            ST_IDLE, ST_TX, ST_IGNORE: byte_ok = 1'b0;
        endcase
    end

    // Byte the slave sends on a read instruction
    assign tx_byte = instr_r.saved_sel ?
                     saved_r[instr_r.pot][instr_r.rptr] :
                     wiper_r[instr_r.pot];

    // Protocol engine: bits counted on rising, line moved on falling
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r      <= ST_IDLE;
            bit_cnt_r    <= 4'h0;
            shift_r      <= 8'h00;
            instr_r      <= '0;
            master_ack_r <= 1'b0;
            sda_oe_n_r   <= 1'b1;
        end else if (start_det) begin
            // A start restarts even an ignored transfer
            state_r    <= ST_ID;
            bit_cnt_r  <= 4'h0;
            sda_oe_n_r <= 1'b1;
        end else if (stop_det) begin
            state_r    <= ST_IDLE;
            bit_cnt_r  <= 4'h0;
            sda_oe_n_r <= 1'b1;
        end else if (state_r == ST_IDLE || state_r == ST_IGNORE) begin
            sda_oe_n_r <= 1'b1;
        end else if (scl_rise) begin
            if (bit_cnt_r < BIT_ACK) begin
                if (state_r != ST_TX) begin
                    shift_r <= {shift_r[6:0], sda_s};
                end
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (bit_cnt_r == BIT_ACK) begin
                master_ack_r <= ~sda_s;
                bit_cnt_r    <= BIT_DONE;
            end
        end else if (scl_fall) begin
            if (bit_cnt_r == BIT_ACK) begin
                // Ninth clock: acknowledge by pulling low, else release
                if (state_r == ST_TX) begin
                    sda_oe_n_r <= 1'b1;
                end else if (byte_ok) begin
                    sda_oe_n_r <= 1'b0;
                    if (state_r == ST_INSTR) begin
                        instr_r <= dpts_instr_type'(shift_r);
                    end
                end else begin
                    sda_oe_n_r <= 1'b1;
                    if (state_r == ST_ID) begin
                        state_r <= ST_IGNORE;
                    end
                end
            end else if (bit_cnt_r == BIT_DONE) begin
                bit_cnt_r  <= 4'h0;
                sda_oe_n_r <= 1'b1;
                unique case (state_r)
                    ST_ID: begin
                        state_r <= ST_INSTR;
                    end
                    ST_INSTR: begin
                        if (instr_r.rd) begin
                            // First bit goes out right after this edge
                            state_r    <= ST_TX;
                            shift_r    <= tx_byte;
                            sda_oe_n_r <= tx_byte[7];
                        end else begin
                            state_r <= ST_RX;
                        end
                    end
                    ST_RX: begin
                        state_r <= ST_RX;  // Further bytes rewrite
                    end
                    ST_TX: begin
                        // Master acknowledged: send the byte again
                        if (master_ack_r) begin
                            shift_r    <= tx_byte;
                            sda_oe_n_r <= tx_byte[7];
                        end else begin
                            state_r <= ST_IGNORE;
                        end
                    end
                    ST_IDLE, ST_IGNORE: begin
                        state_r <= state_r;
                    end
                endcase
            end else if (state_r == ST_TX && bit_cnt_r != 4'h0) begin
                // One new bit per clock, only after the falling edge
                shift_r    <= {shift_r[6:0], 1'b0};
                sda_oe_n_r <= shift_r[6];
            end
        end
    end

    // Output value is always low; only the enable moves the line
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sda_out_r <= 1'b0;
        end else begin
            sda_out_r <= 1'b0;
        end
    end

    assign sda_out  = sda_out_r;
    assign sda_oe_n = sda_oe_n_r;

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    logic recall_req;
    logic status_wr;
    logic recall_pend_r;
    logic refused_r;
    logic busy;
    logic [7:0] rdata_r;

    assign recall_req = bus_req.wr && (bus_req.addr == REG_CONTROL) &&
                        bus_req.wdata[CTRL_RECALL_BIT];
    assign status_wr  = bus_req.wr && (bus_req.addr == REG_STATUS);
    assign busy       = (state_r != ST_IDLE) && (state_r != ST_IGNORE);

    // Sticky refusal flag; a new refusal beats a clear in one cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            refused_r <= 1'b0;
        end else if (refuse_evt) begin
            refused_r <= 1'b1;
        end else if (status_wr && bus_req.wdata[STAT_REFUSED_BIT]) begin
            refused_r <= 1'b0;
        end
    end

    // Read data stands for exactly the cycle after the strobe
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                REG_WIPER0:  rdata_r <= wiper_r[0];
                REG_WIPER1:  rdata_r <= wiper_r[1];
                REG_STATUS: begin
                    rdata_r                   <= 8'h00;
                    rdata_r[STAT_BUSY_BIT]    <= busy;
                    rdata_r[STAT_REFUSED_BIT] <= refused_r;
                    rdata_r[STAT_WP_BIT]      <= wp_s;
                end
                default:     rdata_r <= 8'h00;  // Unmapped reads zero
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata = rdata_r;

    // ---------------------------------------------------------------
    // Potentiometer registers
    // ---------------------------------------------------------------
    // Reset takes constants only, so the recall runs one cycle later
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            recall_pend_r <= 1'b1;
        end else begin
            recall_pend_r <= 1'b0;
        end
    end

    // Saved positions; a real part keeps these in nonvolatile cells
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int p = 0; p < POTS; p++) begin
                for (int s = 0; s < SAVED_NUM; s++) begin
                    saved_r[p][s] <= SAVED_RESET;
                end
            end
        end else if (write_fire && instr_r.saved_sel) begin
            saved_r[instr_r.pot][instr_r.rptr] <= shift_r;
        end
    end

    // Wiper positions: recall from the default saved slot or write
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int p = 0; p < POTS; p++) begin
                wiper_r[p] <= WIPER_RESET;
            end
        end else if (recall_pend_r || recall_req) begin
            for (int p = 0; p < POTS; p++) begin
                wiper_r[p] <= saved_r[p][0];
            end
        end else if (write_fire && !instr_r.saved_sel) begin
            wiper_r[instr_r.pot] <= shift_r;
        end
    end

    // ---------------------------------------------------------------
    // Tap switch enables
    // ---------------------------------------------------------------
    // Each wiper value turns on one of the tap switches
    dpts_tap_decoder u_dec0 (
        .mclk    (mclk),
        .reset_n (reset_n),
        .wiper   (wiper_r[0]),
        .tap_en  (wiper_out_0)
    );

    dpts_tap_decoder u_dec1 (
        .mclk    (mclk),
        .reset_n (reset_n),
        .wiper   (wiper_r[1]),
        .tap_en  (wiper_out_1)
    );

endmodule // dpts_core

// file: testbench/dpts_core_properties.sv
// Port checker for the dual potentiometer serial slave
module dpts_core_checker
    import dpts_pkg::*;
(
    input wire logic             mclk,
    input wire logic             reset_n,
    input wire logic             scl,
    input wire logic             sda_out,
    input wire logic             sda_oe_n,
    input wire logic             wp,
    input wire dpts_bus_req_type bus_req,
    input wire logic [7:0]       rdata,
    input wire logic [TAPS-1:0]  wiper_out_0,
    input wire logic [TAPS-1:0]  wiper_out_1
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------
    // One clock domain, so clock and reset are given once
    // ----------------------------------------------------------
    default clocking dck @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Register port reads of interest
    wire rd_w0 = bus_req.rd && bus_req.addr == REG_WIPER0;
    wire rd_w1 = bus_req.rd && bus_req.addr == REG_WIPER1;
    wire rd_st = bus_req.rd && bus_req.addr == REG_STATUS;

    // ----------------------------------------------------------
    // Data line
    // ----------------------------------------------------------
    AST_SDA_NEVER_HIGH: assert property (!sda_out)
        else $error("Data line driven high");
    AST_HOLD_BOUNDED: assert property (
        $fell(sda_oe_n) |-> ##[1:200] sda_oe_n)
        else $error("Data line held low too long");
    // Moving while the clock is high would read as start or stop
    AST_MOVES_WHILE_LOW: assert property (
        $changed(sda_oe_n) |-> !$past(scl))
        else $error("Data line moved while clock high");

    // ----------------------------------------------------------
    // Tap switches and register port
    // ----------------------------------------------------------
    AST_TAP_ONEHOT_0: assert property ($onehot(wiper_out_0))
        else $error("Pot 0 taps not one-hot");
    AST_TAP_ONEHOT_1: assert property ($onehot(wiper_out_1))
        else $error("Pot 1 taps not one-hot");
    AST_TAP_MATCH_0: assert property (
        rd_w0 |=> wiper_out_0 == (TAP_RESET << rdata))
        else $error("Pot 0 tap differs from wiper value");
    AST_TAP_MATCH_1: assert property (
        rd_w1 |=> wiper_out_1 == (TAP_RESET << rdata))
        else $error("Pot 1 tap differs from wiper value");
    AST_RDATA_QUIET: assert property (
        !bus_req.rd |=> rdata == 8'h00)
        else $error("Read data outside read slot");
    AST_UNMAPPED_ZERO: assert property (
        bus_req.rd && bus_req.addr > REG_CONTROL |=> rdata == 8'h00)
        else $error("Unmapped read gave data");
    AST_WP_STATUS: assert property (
        $stable(wp) [*4] ##0 rd_st |=> rdata[STAT_WP_BIT] == $past(wp))
        else $error("Status shows wrong protect level");

    // Main scenarios reached
    COV_ACK: cover property ($fell(sda_oe_n));
    COV_IDLE_RECALL: cover property ($changed(wiper_out_0) && scl);
    COV_WP_READ: cover property (!wp && rd_st);
endmodule // dpts_core_checker

bind dpts_core dpts_core_checker u_checker (
    .mclk(mclk), .reset_n(reset_n), .scl(scl), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .wp(wp), .bus_req(bus_req), .rdata(rdata),
    .wiper_out_0(wiper_out_0), .wiper_out_1(wiper_out_1)
);

// file: testbench/dpts_master_model.sv
// Behavioural two-wire bus master that clocks the slave under test
module dpts_master_model (
    input  wire logic mclk,
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------
    // Idle bus: both lines released to the pull-up
    // ----------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // Start: data falls while the clock is high
    task automatic start_cond();
        @(posedge mclk) sda_m <= 1'b1;
        scl <= 1'b1;
        repeat (4) @(posedge mclk);
        sda_m <= 1'b0;
        repeat (4) @(posedge mclk);
        scl <= 1'b0;
    endtask

    // Stop: data rises while the clock is high
    task automatic stop_cond();
        repeat (3) @(posedge mclk);
        sda_m <= 1'b0;
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (4) @(posedge mclk);
        sda_m <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask

    // One 80 ns bit: data set mid-low, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        repeat (3) @(posedge mclk);
        sda_m <= b;
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (2) @(posedge mclk);
        s = sda;
        @(posedge mclk) scl <= 1'b0;
    endtask

    // Byte plus ninth clock; the low after it is stretched so the
    // slave has released the line before our next bit is set
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack);
        repeat (4) @(posedge mclk);
    endtask
endmodule // dpts_master_model

// file: testbench/dpts_core_tb.sv
// Self-checking bench for the dual potentiometer serial slave
module dpts_core_tb
    import dpts_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic             mclk = 1'b0;
    logic             reset_n = 1'b0;
    logic             scl, sda_m, sda_out, sda_oe_n;
    logic [2:0]       strap = 3'h0;
    logic             wp = 1'b1;
    dpts_bus_req_type bus_req = '0;
    logic [7:0]       rdata;
    logic [7:0]       rep_got;
    logic [TAPS-1:0]  tap0, tap1;
    int               fail_count = 0;
    int               samples_checked = 0;
    // Pull-up wins unless somebody pulls low
    wire              sda_in = sda_m & (sda_oe_n | sda_out);

    always #5 mclk = ~mclk;

    dpts_core dut (
        .mclk(mclk), .reset_n(reset_n), .scl(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .address_strap_inputs(strap), .wp(wp), .bus_req(bus_req),
        .rdata(rdata), .wiper_out_0(tap0), .wiper_out_1(tap1)
    );
    dpts_master_model mdl (
        .mclk(mclk), .scl(scl), .sda_m(sda_m), .sda(sda_in)
    );

    // ----------------------------------------------------------
    // Expectations, comparisons and closing
    // ----------------------------------------------------------
    function automatic logic [TAPS-1:0] tap_of(input logic [7:0] v);
        return TAP_RESET << v;
    endfunction
    function automatic logic [7:0] id_of(input logic [2:0] s);
        return {DEV_TYPE_DEFAULT, 1'b0, s};
    endfunction
    function automatic logic [7:0] ins(input int rd, sv,
                                       input logic [1:0] idx, input logic p);
        return {rd[0], 2'b00, sv[0], idx, 1'b0, p};
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_tap(input logic [TAPS-1:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------
    // Register port and serial frame drivers
    // ----------------------------------------------------------
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk) bus_req <= '0;
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk) bus_req <= '{addr: a, wdata: 8'h00,
                                     wr: 1'b0, rd: 1'b1};
        @(posedge mclk) bus_req <= '0;
        #1 d = rdata;
    endtask
    // Acks packed id, instruction, data; 0 means acknowledged
    task automatic frame(input logic [7:0] id, ib, dat, input int rd,
                         output logic [7:0] got, output logic [2:0] ak);
        logic [7:0] junk;
        mdl.start_cond();
        mdl.xfer(id, 1'b1, junk, ak[2]);
        mdl.xfer(ib, 1'b1, junk, ak[1]);
        mdl.xfer(rd ? 8'hFF : dat, rd ? 1'b0 : 1'b1, got, ak[0]);
        // A read is acked once, so the slave must repeat the same byte
        if (rd != 0) mdl.xfer(8'hFF, 1'b1, rep_got, junk[0]);
        mdl.stop_cond();
        repeat (8) @(posedge mclk);
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        logic [7:0] v, got;
        logic [7:0] sv [2];
        logic [2:0] ak;
        void'($urandom(6097));
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
        #1 chk_tap(tap0, tap_of(SAVED_RESET));
        chk_tap(tap1, tap_of(SAVED_RESET));
        bus_rd(4'hF, got);
        chk8(got, 8'h00);
        // Every strap setting; extreme wiper values at both ends
        for (int s = 0; s < 8; s++) begin
            v = (s == 0) ? 8'hFF : (s == 7) ? 8'h00 : 8'($urandom);
            strap <= 3'(s);
            frame(id_of(3'(s)) ^ {4'h0, s[1], 3'h0},
                  ins(0, 0, 2'h0, s[0]), v, 0, got, ak);
            chk8({5'h00, ak}, 8'h00);
            chk_tap(s[0] ? tap1 : tap0, tap_of(v));
            bus_rd(s[0] ? REG_WIPER1 : REG_WIPER0, got);
            chk8(got, v);
            frame(id_of(3'(s)), ins(1, 0, 2'h0, s[0]), 8'h00, 1, got, ak);
            chk8(got, v);
            chk8(rep_got, v);
            frame(id_of(3'(s)) ^ (s[1] ? 8'h50 : 8'h05),
                  ins(0, 0, 2'h0, s[0]), ~v, 0, got, ak);
            chk8({5'h00, ak}, 8'h07);
            chk_tap(s[0] ? tap1 : tap0, tap_of(v));
        end
        // Protected saved write: no ack, flag set, slot unchanged
        wp <= 1'b0;
        frame(id_of(3'h7), ins(0, 1, 2'h1, 1'b0), 8'h3C, 0, got, ak);
        chk8({5'h00, ak}, 8'h01);
        bus_rd(REG_STATUS, got);
        chk8(got, 8'(1 << STAT_REFUSED_BIT));
        bus_wr(REG_STATUS, 8'(1 << STAT_REFUSED_BIT));
        bus_rd(REG_STATUS, got);
        chk8(got, 8'h00);
        frame(id_of(3'h7), ins(1, 1, 2'h1, 1'b0), 8'h00, 1, got, ak);
        chk8(got, SAVED_RESET);
        wp <= 1'b1;
        // All four saved slots of each pot, then recall slot zero
        for (int p = 0; p < 2; p++) begin
            sv[p] = 8'($urandom);
            for (int i = 0; i < 4; i++) begin
                frame(id_of(3'h7), ins(0, 1, 2'(i), p[0]), sv[p] ^ 8'(i),
                      0, got, ak);
                chk8({5'h00, ak}, 8'h00);
                frame(id_of(3'h7), ins(1, 1, 2'(i), p[0]), 8'h00, 1, got, ak);
                chk8(got, sv[p] ^ 8'(i));
            end
        end
        bus_rd(REG_STATUS, got);
        chk8(got, 8'(1 << STAT_WP_BIT));
        bus_wr(REG_CONTROL, 8'(1 << CTRL_RECALL_BIT));
        repeat (6) @(posedge mclk);
        #1 chk_tap(tap0, tap_of(sv[0]));
        chk_tap(tap1, tap_of(sv[1]));
        end_of_test();
    end

    // Hang guard, far beyond the roughly 12300 cycles the tests need
    initial begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        end_of_test();
    end
endmodule // dpts_core_tb
